// ### src/led_sink_shift_latch_errdet.sv
// Serial-in parallel-out control with latch, global enable and fault capture.
`timescale 1ns/1ps

module led_sink_shift_latch_errdet #(
    parameter int unsigned CHANNEL_COUNT = 8                     // Number of sink channels
) (
    input  wire logic                     mclk_in,                              // System clock, 200 MHz
    input  wire logic                     reset_in,                             // Asynchronous reset, high
    input  wire logic                     serial_clock_in,                      // Host serial clock pin
    input  wire logic                     serial_in,                            // Host serial data pin
    input  wire logic                     latch_enable_detect_mode_one_in,      // Latch enable pin
    input  wire logic                     output_enable_detect_mode_two_n_in,   // Output enable pin, low
    input  wire logic [CHANNEL_COUNT-1:0] open_below_threshold_in,             // Current under open threshold
    input  wire logic [CHANNEL_COUNT-1:0] short_above_set_in,                  // Voltage over short set level
    input  wire logic [CHANNEL_COUNT-1:0] short_below_clear_in,                // Voltage under clear level
    output logic                          serial_out,                          // Chain output pin
    output logic [CHANNEL_COUNT-1:0]      channel_sinks_out                    // Channel sink on commands
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The shift path takes a slice below the top bit, so one channel is refused
    generate
        if (CHANNEL_COUNT < 2) begin : g_width_check
            $error("CHANNEL_COUNT must be at least two");
        end
    endgenerate

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam int unsigned SYNC_WIDTH = 4 + 3 * CHANNEL_COUNT;   // All pins taken through the synchroniser
    // Idle pin levels after reset, so no false enable follows reset
    localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = SYNC_WIDTH'(led_sink_pkg::PIN_IDLE);

    // Mode of the fault logic
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h1,                                       // Ordinary shift and latch
        MODE_ARMED  = 3'h2,                                       // Detect mode, capture allowed
        MODE_SPENT  = 3'h4                                        // Detect mode, capture used up
    } mode_state_type;

    logic [SYNC_WIDTH-1:0]    sync_first_reg;                     // First synchroniser stage
    logic [SYNC_WIDTH-1:0]    sync_second_reg;                    // Second synchroniser stage
    logic                     sclk_prev_reg;                      // Serial clock one cycle back
    logic                     sclk_now;                           // Synchronised serial clock
    logic                     data_now;                           // Synchronised serial data
    logic                     latch_now;                          // Synchronised latch enable
    logic                     enable_n_now;                       // Synchronised output enable
    logic [CHANNEL_COUNT-1:0] open_now;                           // Synchronised open comparators
    logic [CHANNEL_COUNT-1:0] short_set_now;                      // Synchronised short set comparators
    logic [CHANNEL_COUNT-1:0] short_clear_now;                    // Synchronised short clear comparators
    logic                     sclk_rise;                          // Rising serial clock seen
    logic                     sclk_fall;                          // Falling serial clock seen
    logic [CHANNEL_COUNT-1:0] shift_reg;                          // Serial shift register
    logic [CHANNEL_COUNT-1:0] shift_next;                         // Its next value on a rising clock
    logic [CHANNEL_COUNT-1:0] output_ctrl_reg;                    // Output control latch
    logic [CHANNEL_COUNT-1:0] short_flag_reg;                     // Short detection with hysteresis
    logic [CHANNEL_COUNT-1:0] fault_flags;                        // Per-channel fault status
    logic [4:0]               latch_hist_reg;                     // Latch samples of last five clocks
    logic [4:0]               enable_n_hist_reg;                  // Enable samples of last five clocks
    logic [4:0]               latch_hist_next;                    // History including this clock
    logic [4:0]               enable_n_hist_next;                 // History including this clock
    logic                     entry_seen;                         // Entry command completes now
    logic                     exit_seen;                          // Exit command completes now
    mode_state_type           mode_reg;                           // Fault logic mode
    mode_state_type           mode_next;                          // Its next value
    logic [1:0]               capture_count_reg;                  // Enable-low clocks while armed
    logic                     capture_load;                       // Shift register loads faults now

    // ************************************************************
    // Decoding shared by the entry and exit commands
    // ************************************************************
    // True when both sampled histories match a command shape
    function automatic logic command_match(
        input logic [4:0] latch_hist,
        input logic [4:0] enable_n_hist,
        input logic [4:0] latch_shape
    );
        command_match = (latch_hist == latch_shape) &&
                        (enable_n_hist == led_sink_pkg::CMD_ENABLE_N_SHAPE);
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Every pin is asynchronous to mclk, so it passes two flip-flops
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sync_first_reg  <= SYNC_RESET;
            sync_second_reg <= SYNC_RESET;
        end else begin
            sync_first_reg  <= {short_below_clear_in, short_above_set_in, open_below_threshold_in,
                                output_enable_detect_mode_two_n_in, latch_enable_detect_mode_one_in,
                                serial_in, serial_clock_in};
            sync_second_reg <= sync_first_reg;
        end
    end

    // Split the second stage into named signals
    always_comb begin
        sclk_now        = sync_second_reg[0];
        data_now        = sync_second_reg[1];
        latch_now       = sync_second_reg[2];
        enable_n_now    = sync_second_reg[3];
        open_now        = sync_second_reg[4 +: CHANNEL_COUNT];
        short_set_now   = sync_second_reg[4 + CHANNEL_COUNT +: CHANNEL_COUNT];
        short_clear_now = sync_second_reg[4 + 2 * CHANNEL_COUNT +: CHANNEL_COUNT];
    end

    // ************************************************************
    // Serial clock edges
    // ************************************************************
    // Previous clock level for edge detection, taken from stage two only
    // Reset low matches the idle serial clock, so no false rise follows reset
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sclk_prev_reg <= 1'h0;
        end else begin
            sclk_prev_reg <= sclk_now;
        end
    end

    // One-cycle enables for each serial clock edge
    always_comb begin
        sclk_rise = sclk_now && !sclk_prev_reg;
        sclk_fall = !sclk_now && sclk_prev_reg;
    end

    // ************************************************************
    // Fault detection
    // ************************************************************
    // Per channel: short flag with hysteresis, only for a driven sink
    // Set wins when set and clear comparators both report in one cycle
    generate
        for (genvar ch = 0; ch < CHANNEL_COUNT; ch++) begin : g_short
            always_ff @(posedge mclk_in or posedge reset_in) begin
                if (reset_in) begin
                    short_flag_reg[ch] <= 1'h0;
                end else if (!channel_sinks_out[ch]) begin
                    // Channel off, no detection possible
                    short_flag_reg[ch] <= 1'h0;
                end else if (short_set_now[ch]) begin
                    short_flag_reg[ch] <= 1'h1;
                end else if (short_clear_now[ch]) begin
                    short_flag_reg[ch] <= 1'h0;
                end
            end
        end
    endgenerate

    // Open comparator is read live; only the short path keeps state
    // Fault is one for an error, zero for normal or an off channel
    always_comb begin
        fault_flags = channel_sinks_out & (open_now | short_flag_reg);
    end

    // ************************************************************
    // Command recogniser
    // ************************************************************
    // Histories grow by the levels sampled at this rising clock
    // Sliding window: normal traffic matching a shape counts as a command
    always_comb begin
        latch_hist_next    = {latch_hist_reg[3:0], latch_now};
        enable_n_hist_next = {enable_n_hist_reg[3:0], enable_n_now};
        entry_seen = command_match(latch_hist_next, enable_n_hist_next,
                                   led_sink_pkg::ENTRY_LATCH_SHAPE);
        exit_seen  = command_match(latch_hist_next, enable_n_hist_next,
                                   led_sink_pkg::EXIT_LATCH_SHAPE);
    end

    // Window of the last five serial clocks
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            latch_hist_reg    <= ~led_sink_pkg::HISTORY_RESET;
            enable_n_hist_reg <= led_sink_pkg::HISTORY_RESET;
        end else if (sclk_rise) begin
            latch_hist_reg    <= latch_hist_next;
            enable_n_hist_reg <= enable_n_hist_next;
        end
    end

    // ************************************************************
    // Mode state machine
    // ************************************************************
    // Entry arms one capture; a finished capture spends it; exit leaves
    // Capture needs three enable-low clocks before release to be spent
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_NORMAL: begin
                if (entry_seen) begin
                    mode_next = MODE_ARMED;
                end
            end
            MODE_ARMED: begin
                if (exit_seen) begin
                    mode_next = MODE_NORMAL;
                end else if (enable_n_now && capture_count_reg == led_sink_pkg::CAPTURE_MIN_CLOCKS) begin
                    mode_next = MODE_SPENT;
                end
            end
            MODE_SPENT: begin
                if (exit_seen) begin
                    mode_next = MODE_NORMAL;
                end else if (entry_seen) begin
                    mode_next = MODE_ARMED;
                end
            end
            default: begin
                mode_next = MODE_NORMAL;
            end
        endcase
    end

    // Mode advances only on rising serial clocks
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_reg <= MODE_NORMAL;
        end else if (sclk_rise) begin
            mode_reg <= mode_next;
        end
    end

    // Counts enable-low clocks while armed, saturating at the minimum
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            capture_count_reg <= 2'h0;
        end else if (sclk_rise) begin
            if (mode_reg != MODE_ARMED || enable_n_now) begin
                capture_count_reg <= 2'h0;
            end else if (capture_count_reg != led_sink_pkg::CAPTURE_MIN_CLOCKS) begin
                capture_count_reg <= capture_count_reg + 2'h1;
            end
        end
    end

    // A single enable-low clock while armed, as in the exit command, loads too
    // Faults load only while armed and enable is held low
    always_comb begin
        capture_load = (mode_reg == MODE_ARMED) && !enable_n_now;
    end

    // ************************************************************
    // Shift register
    // ************************************************************
    // Shift towards the top so the first bit ends highest, else load faults
    always_comb begin
        if (capture_load) begin
            shift_next = fault_flags;
        end else begin
            shift_next = {shift_reg[CHANNEL_COUNT-2:0], data_now};
        end
    end

    // Every rising serial clock updates the register
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            shift_reg <= '0;
        end else if (sclk_rise) begin
            shift_reg <= shift_next;
        end
    end

    // Top bit goes out on the falling clock for the next device
    // A chained device then sees it settled well before its own rising clock
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            serial_out <= led_sink_pkg::SERIAL_OUT_RESET;
        end else if (sclk_fall) begin
            serial_out <= shift_reg[CHANNEL_COUNT-1];
        end
    end

    // ************************************************************
    // Output latch and channel drive
    // ************************************************************
    // Transparent while latch enable is high, holds while low
    // Follows the synchronised level, so it trails the pin by a few mclk cycles
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            output_ctrl_reg <= '0;
        end else if (latch_now) begin
            output_ctrl_reg <= shift_reg;
        end
    end
    // Latch low: output_ctrl_reg keeps its value

    // Enable low drives channels from the latch, including the entry glitch
    // Registered, so the sinks never see a decoding glitch of their own
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            channel_sinks_out <= '0;
        end else if (!enable_n_now) begin
            channel_sinks_out <= output_ctrl_reg;
        end else begin
            channel_sinks_out <= '0;
        end
    end

endmodule

// ### inc/led_sink_pkg.sv
// Constants shared by the serial LED sink controller.
//
// Notes on behaviour
// - Eight-bit register shifts on each rising clock.
// - First bit shifted lands in top position.
// - Serial output shows top bit, falling edge.
// - Register always shifts or loads faults.
// - Latch enable high: output register follows.
// - Latch enable low: output register holds.
// - Enable low drives channels, high all off.
// - Entry command spans five serial clocks.
// - Entry latches at four, glitches at two.
// - Capture only honoured after entry command.
// - One capture per entry into mode.
// - During capture hold, load faults, ignore input.
// - Channel seven fault on output next fall.
// - Fault bit one, normal bit zero.
// - Fault is open or short detected.
// - Open flagged only for enabled low-current channel.
// - Short flag set high, cleared low threshold.
// - Exit: latch low five clocks, enable second.
package led_sink_pkg;

    // ************************************************************
    // Command recognition
    // ************************************************************
    localparam int unsigned CMD_CLOCKS         = 5;        // Clocks in one command window
    // History bit 4 holds clock one of the window, bit 0 clock five
    localparam logic [4:0]  CMD_ENABLE_N_SHAPE = 5'h17;    // Enable low at clock two only
    localparam logic [4:0]  ENTRY_LATCH_SHAPE  = 5'h02;    // Latch high at clock four only
    localparam logic [4:0]  EXIT_LATCH_SHAPE   = 5'h00;    // Latch low throughout
    localparam logic [1:0]  CAPTURE_MIN_CLOCKS = 2'h3;     // Least enable-low clocks for a capture

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [4:0]  HISTORY_RESET      = 5'h1f;    // Enable idle high, latch idle low
    localparam logic        SERIAL_OUT_RESET   = 1'h0;     // Serial output after reset
    localparam logic [3:0]  PIN_IDLE           = 4'h8;     // Clock, data, latch low; enable high

    // ************************************************************
    // Synchroniser depth
    // ************************************************************
    localparam int unsigned SYNC_STAGES        = 2;        // Flip-flops ahead of any logic

endpackage

// ### verif/led_sink_checker.sv
// Concurrent checks on the pins of the LED sink shift, latch and fault block.
`timescale 1ns/1ps

module led_sink_checker #(
    parameter int unsigned CHANNEL_COUNT = 8        // Number of sink channels
) (
    input wire logic                     mclk_in,                             // System clock
    input wire logic                     reset_in,                            // Asynchronous reset, high
    input wire logic                     serial_clock_in,                     // Host serial clock pin
    input wire logic                     latch_enable_detect_mode_one_in,     // Latch enable pin
    input wire logic                     output_enable_detect_mode_two_n_in,  // Output enable pin, low
    input wire logic                     serial_out,                          // Chain output pin
    input wire logic [CHANNEL_COUNT-1:0] channel_sinks_out                    // Channel sinks
);
    logic [7:0] enable_n_hist_reg;                  // Past enable pin samples, newest in bit 0

    // ************************************************************
    // Helper history
    // ************************************************************
    // Keeps recent enable samples so a lit channel can be traced to its cause
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            enable_n_hist_reg <= 8'hff;
        end else begin
            enable_n_hist_reg <= {enable_n_hist_reg[6:0], output_enable_detect_mode_two_n_in};
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    // ************************************************************
    // Assertions
    // ************************************************************
    off_when_disabled_a : assert property (
        output_enable_detect_mode_two_n_in [*6] |-> channel_sinks_out == '0)
        else $error("channels lit while outputs disabled");
    disable_prompt_a : assert property (
        $rose(output_enable_detect_mode_two_n_in) |-> ##[1:6] channel_sinks_out == '0)
        else $error("channels not switched off after disable");
    lit_needs_enable_a : assert property (
        |channel_sinks_out |-> !output_enable_detect_mode_two_n_in || !(&enable_n_hist_reg[5:0]))
        else $error("channel lit without recent enable");
    dark_after_reset_a : assert property ($fell(reset_in) |-> channel_sinks_out == '0 && serial_out == 1'b0)
        else $error("outputs not cleared after reset");
    hold_when_closed_a : assert property (
        (!latch_enable_detect_mode_one_in && $stable(output_enable_detect_mode_two_n_in)) [*8]
        |-> $stable(channel_sinks_out))
        else $error("channels moved while latch closed");
    out_on_fall_a : assert property (
        $changed(serial_out) |-> !$past(serial_clock_in, 2) && $past(serial_clock_in, 7))
        else $error("serial output moved away from a falling clock");
    out_steady_high_a : assert property (serial_clock_in [*6] |-> $stable(serial_out))
        else $error("serial output moved while clock high");
    out_steady_low_a : assert property ((!serial_clock_in) [*7] |-> $stable(serial_out))
        else $error("serial output moved late in clock low phase");
endmodule

bind led_sink_shift_latch_errdet led_sink_checker #(.CHANNEL_COUNT(CHANNEL_COUNT)) i_checker (
    .mclk_in                            (mclk_in),
    .reset_in                           (reset_in),
    .serial_clock_in                    (serial_clock_in),
    .latch_enable_detect_mode_one_in    (latch_enable_detect_mode_one_in),
    .output_enable_detect_mode_two_n_in (output_enable_detect_mode_two_n_in),
    .serial_out                         (serial_out),
    .channel_sinks_out                  (channel_sinks_out)
);

// ### verif/led_host_model.sv
// Host controller model driving serial clock, data, latch and enable pins.
`timescale 1ns/1ps

module led_host_model (
    input  wire logic mclk_in,           // System clock, pins change on its fall
    input  wire logic serial_out_in,     // Chain output of the block
    output logic      serial_clock_out,  // Serial clock, still and low between frames
    output logic      serial_data_out,   // Serial data
    output logic      latch_out,         // Latch enable
    output logic      enable_n_out       // Output enable, low
);
    // Idle pin levels from time zero
    initial begin
        serial_clock_out = 1'b0;
        serial_data_out  = 1'b0;
        latch_out        = 1'b0;
        enable_n_out     = 1'b1;
    end

    // One serial clock; returns the serial output seen just before the rise
    task automatic cyc(input logic d, input logic latch, input logic enable_n, output logic so);
        @(negedge mclk_in);
        serial_data_out = d;
        latch_out       = latch;
        enable_n_out    = enable_n;
        repeat (8) @(negedge mclk_in);
        so               = serial_out_in;
        serial_clock_out = 1'b1;
        repeat (8) @(negedge mclk_in);
        serial_clock_out = 1'b0;
        serial_data_out  = ~d;          // Data no longer valid: show its inverse
    endtask

    // Pin levels changed with the serial clock standing still
    task automatic set_pins(input logic latch, input logic enable_n);
        @(negedge mclk_in);
        latch_out    = latch;
        enable_n_out = enable_n;
        repeat (8) @(negedge mclk_in);
    endtask

    // Eight bits most significant first, reading the outgoing bits meanwhile
    task automatic load_byte(input logic [7:0] b, input logic enable_n, output logic [7:0] rd);
        for (int i = 7; i >= 0; i--) begin
            cyc(b[i], 1'b0, enable_n, rd[i]);
        end
    endtask

    // Five-clock command with enable low at clock two only
    task automatic cmd(input logic [4:0] latch_shape);
        logic so;
        for (int k = 4; k >= 0; k--) begin
            cyc(1'b0, latch_shape[k], led_sink_pkg::CMD_ENABLE_N_SHAPE[k], so);
        end
    endtask

    // Enable held low for a number of clocks
    task automatic capture(input int n, input logic d);
        logic so;
        for (int k = 0; k < n; k++) begin
            cyc(d, 1'b0, 1'b0, so);
        end
    endtask
endmodule

// ### verif/led_sink_shift_latch_errdet_tb.sv
// Self-checking bench for the LED sink shift, latch and fault capture block.
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module led_sink_shift_latch_errdet_tb;
    logic       mclk, reset, sclk, sdata, latch, enable_n, sout;  // Clock, reset and serial pins
    logic [7:0] sinks, open_below, short_above, short_below, rd;  // Channels, comparators, read data
    int         err_count    = 0;                                 // Mismatches
    int         total_checks = 0;                                 // Comparisons made

    led_host_model i_host (.mclk_in(mclk), .serial_out_in(sout), .serial_clock_out(sclk),
        .serial_data_out(sdata), .latch_out(latch), .enable_n_out(enable_n));
    led_sink_shift_latch_errdet i_dut (.mclk_in(mclk), .reset_in(reset), .serial_clock_in(sclk),
        .serial_in(sdata), .latch_enable_detect_mode_one_in(latch), .output_enable_detect_mode_two_n_in(enable_n),
        .open_below_threshold_in(open_below), .short_above_set_in(short_above),
        .short_below_clear_in(short_below), .serial_out(sout), .channel_sinks_out(sinks));

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Prints counts and the verdict, then ends the run
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Shifting, latch transparency and hold, global enable
    task automatic t_normal();
        logic so;
        i_host.load_byte(8'ha5, 1'b1, rd);
        i_host.set_pins(1'b1, 1'b1);
        i_host.set_pins(1'b0, 1'b0);
        `CHECK_EQ(sinks, 8'ha5)
        i_host.load_byte(8'h3c, 1'b0, rd);
        `CHECK_EQ(rd, 8'ha5)
        `CHECK_EQ(sinks, 8'ha5)
        i_host.set_pins(1'b1, 1'b0);
        `CHECK_EQ(sinks, 8'h3c)
        i_host.cyc(1'b1, 1'b1, 1'b0, so);
        `CHECK_EQ(sinks, 8'h79)
        i_host.set_pins(1'b0, 1'b1);
        `CHECK_EQ(sinks, 8'h00)
    endtask

    // Capture pattern without entry shifts data as usual
    task automatic t_no_entry();
        open_below = 8'hff;
        i_host.load_byte(8'hff, 1'b1, rd);
        i_host.capture(3, 1'b0);
        i_host.load_byte(8'h00, 1'b1, rd);
        `CHECK_EQ(rd, 8'hf8)
    endtask

    // Entry, fault capture with hysteresis, read-out, refused second capture
    task automatic t_fault();
        i_host.load_byte(8'h5a, 1'b1, rd);
        i_host.cmd(led_sink_pkg::ENTRY_LATCH_SHAPE);
        i_host.set_pins(1'b0, 1'b0);
        `CHECK_EQ(sinks, 8'ha0)
        i_host.set_pins(1'b0, 1'b1);
        i_host.load_byte(8'hfe, 1'b1, rd);
        i_host.set_pins(1'b1, 1'b1);
        i_host.set_pins(1'b0, 1'b1);
        open_below  = 8'h81;
        short_above = 8'h10;
        short_below = 8'hef;
        i_host.capture(10, 1'b1);
        short_above = 8'h00;             // Between thresholds: flag must stay
        short_below = 8'h00;
        i_host.capture(15, 1'b1);
        `CHECK_EQ(sinks, 8'hfe)
        i_host.load_byte(8'h00, 1'b1, rd);
        `CHECK_EQ(rd, 8'h90)
        i_host.capture(3, 1'b1);
        i_host.load_byte(8'h00, 1'b1, rd);
        `CHECK_EQ(rd, 8'h07)
    endtask

    // Exit straight after entry leaves capture disarmed
    task automatic t_exit();
        open_below = 8'hff;
        i_host.cmd(led_sink_pkg::ENTRY_LATCH_SHAPE);
        i_host.cmd(led_sink_pkg::EXIT_LATCH_SHAPE);
        i_host.load_byte(8'hff, 1'b1, rd);
        i_host.set_pins(1'b1, 1'b1);
        i_host.set_pins(1'b0, 1'b1);
        i_host.capture(3, 1'b0);
        i_host.load_byte(8'h00, 1'b1, rd);
        `CHECK_EQ(rd, 8'hf8)
    endtask

    // Main sequence
    initial begin
        reset       = 1'b1;
        open_below  = 8'h00;
        short_above = 8'h00;
        short_below = 8'hff;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        t_normal();
        t_no_entry();
        t_fault();
        t_exit();
        conclude();
    end

    // Watchdog, far beyond the expected run of some 12 us
    initial begin
        #100000;
        err_count++;
        conclude();
    end
endmodule
